// *** src/appr_top.sv ***
`timescale 1ns/1ps
module appr_top
#(
    parameter int MIC_HALF = appr_pkg::MIC_CLK_HALF_CYCLES
) (
    // clock and reset
    input  wire logic                      i_ref_clk,
    input  wire logic                      i_rst,
    // register port
    input  wire logic [7:0]                i_reg_addr,
    input  wire logic                      i_reg_wr,
    input  wire logic                      i_reg_rd,
    input  wire logic [7:0]                i_reg_wdata,
    output logic      [7:0]                o_reg_rdata,
    // pins in
    input  wire appr_pkg::appr_pins_t      i_pins,
    input  wire appr_pkg::appr_primary_t   i_primary,
    input  wire logic                      i_sdout_in,
    // serial data output pin drive
    output appr_pkg::appr_pin_drive_t      o_sdout,
    // routed signals
    output logic                           o_primary_din,
    output appr_pkg::appr_secondary_t      o_secondary,
    output logic                           o_mic_clock,
    output appr_pkg::appr_rec_t            o_rec
);
    import appr_pkg::*;

    localparam int CW = (MIC_HALF > 1) ? $clog2(MIC_HALF) : 1;
    localparam logic [CW-1:0] HALF_LAST = CW'(MIC_HALF - 1);

    logic [7:0] output_pin_setup;
    logic [7:0] secondary_clock_route;
    logic [7:0] secondary_data_route;
    logic [7:0] pdm_input_setup;

    logic [2:0] out_pin_drive_style;
    logic [3:0] out_pin_function;
    logic       primary_input_enable;
    logic [2:0] secondary_frame_sync_source;
    logic [2:0] secondary_bit_clock_source;
    logic [2:0] secondary_input1_source;
    logic [2:0] secondary_input2_source;
    logic       rec_ch1_digital_select;
    logic       rec_ch2_digital_select;
    logic       mic_in1_latch_edge;
    logic       mic_in2_latch_edge;
    logic [1:0] mic_in1_source;
    logic [1:0] mic_in2_source;

    assign out_pin_drive_style  = output_pin_setup[OUT_DRIVE_LSB +: 3];
    assign out_pin_function     = output_pin_setup[OUT_FUNC_LSB +: 4];
    assign primary_input_enable = secondary_clock_route[PRIMARY_IN_EN_BIT];
    assign secondary_frame_sync_source =
        secondary_clock_route[SEC_FSYNC_LSB +: 3];
    assign secondary_bit_clock_source =
        secondary_clock_route[SEC_BCLK_LSB +: 3];
    assign secondary_input1_source = secondary_data_route[SEC_IN1_LSB +: 3];
    assign secondary_input2_source = secondary_data_route[SEC_IN2_LSB +: 3];
    assign rec_ch1_digital_select  = pdm_input_setup[REC_CH1_DIG_BIT];
    assign rec_ch2_digital_select  = pdm_input_setup[REC_CH2_DIG_BIT];
    assign mic_in1_latch_edge      = pdm_input_setup[MIC_IN1_EDGE_BIT];
    assign mic_in2_latch_edge      = pdm_input_setup[MIC_IN2_EDGE_BIT];
    assign mic_in1_source          = pdm_input_setup[MIC_IN1_SRC_LSB +: 2];
    assign mic_in2_source          = pdm_input_setup[MIC_IN2_SRC_LSB +: 2];

    // register writes; reserved positions masked so they stay zero
    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            output_pin_setup      <= RST_OUTPUT_PIN_SETUP;
            secondary_clock_route <= RST_SECONDARY_CLOCK_ROUTE;
            secondary_data_route  <= RST_SECONDARY_DATA_ROUTE;
            pdm_input_setup       <= RST_PDM_INPUT_SETUP;
        end else if (i_reg_wr) begin
            case (i_reg_addr)
                ADDR_OUTPUT_PIN_SETUP: begin
                    output_pin_setup <= i_reg_wdata & WMASK_OUTPUT_PIN_SETUP;
                end
                ADDR_SECONDARY_CLOCK_ROUTE: begin
                    secondary_clock_route <= i_reg_wdata &
                        WMASK_SECONDARY_CLOCK_ROUTE;
                end
                ADDR_SECONDARY_DATA_ROUTE: begin
                    secondary_data_route <= i_reg_wdata &
                        WMASK_SECONDARY_DATA_ROUTE;
                end
                ADDR_PDM_INPUT_SETUP: begin
                    pdm_input_setup <= i_reg_wdata & WMASK_PDM_INPUT_SETUP;
                end
                default: begin
                end
            endcase
        end
    end

    // register reads, one cycle after the strobe; unmapped reads zero
    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            o_reg_rdata <= 8'h00;
        end else if (i_reg_rd) begin
            case (i_reg_addr)
                ADDR_OUTPUT_PIN_SETUP:      o_reg_rdata <= output_pin_setup;
                ADDR_SECONDARY_CLOCK_ROUTE: o_reg_rdata <= secondary_clock_route;
                ADDR_SECONDARY_DATA_ROUTE:  o_reg_rdata <= secondary_data_route;
                ADDR_PDM_INPUT_SETUP:       o_reg_rdata <= pdm_input_setup;
                default:                    o_reg_rdata <= 8'h00;
            endcase
        end
    end

    // three-bit route decode; returns {valid, level}
    // pins passed in so continuous assigns see every level change
    function automatic logic [1:0] route3(
        input logic [2:0] code,
        input appr_pins_t pins,
        input logic [1:0] sdout_route,
        input logic       primary_level
    );
        logic [1:0] r;
        r = 2'b00;
        case (code)
            SRC_PIN_A:   r = {1'b1, pins.multi_pin_a};
            SRC_PIN_B:   r = {1'b1, pins.multi_pin_b};
            SRC_PIN_C:   r = {1'b1, pins.multi_pin_c};
            SRC_SDOUT:   r = sdout_route;
            SRC_PRIMARY: r = {1'b1, primary_level};
            default:     r = 2'b00;
        endcase
        return r;
    endfunction

    // two-bit mic source decode; returns {valid, level}
    function automatic logic [1:0] route2(
        input logic [1:0] code,
        input appr_pins_t pins
    );
        logic [1:0] r;
        r = 2'b00;
        case (code)
            MIC_SRC_PIN_A: r = {1'b1, pins.multi_pin_a};
            MIC_SRC_PIN_B: r = {1'b1, pins.multi_pin_b};
            MIC_SRC_PIN_C: r = {1'b1, pins.multi_pin_c};
            default:       r = 2'b00;
        endcase
        return r;
    endfunction

    logic [1:0] fs_route;
    logic [1:0] bc_route;
    logic [1:0] in1_route;
    logic [1:0] in2_route;
    logic [1:0] mic1_route;
    logic [1:0] mic2_route;

    assign fs_route  = route3(secondary_frame_sync_source, i_pins, 2'b00,
                              i_primary.frame_sync);
    assign bc_route  = route3(secondary_bit_clock_source, i_pins, 2'b00,
                              i_primary.bit_clock);
    assign in1_route = route3(secondary_input1_source, i_pins,
                              {1'b1, i_sdout_in}, i_primary.data_in);
    assign in2_route = route3(secondary_input2_source, i_pins,
                              {1'b1, i_sdout_in}, i_primary.data_in);
    assign mic1_route = route2(mic_in1_source, i_pins);
    assign mic2_route = route2(mic_in2_source, i_pins);

    // primary input gate
    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            o_primary_din <= 1'b0;
        end else begin
            o_primary_din <= primary_input_enable & i_primary.data_in;
        end
    end

    // secondary port needs both clocks routed to run at all
    logic sec_active;
    assign sec_active = fs_route[1] & bc_route[1];

    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            o_secondary <= '0;
        end else begin
            o_secondary.active     <= sec_active;
            o_secondary.frame_sync <= sec_active & fs_route[0];
            o_secondary.bit_clock  <= sec_active & bc_route[0];
            o_secondary.in1_valid  <= sec_active & in1_route[1];
            o_secondary.in1        <= sec_active & in1_route[1] & in1_route[0];
            o_secondary.in2_valid  <= sec_active & in2_route[1];
            o_secondary.in2        <= sec_active & in2_route[1] & in2_route[0];
        end
    end

    // mic clock divider, free running so strobes are always known
    logic [CW-1:0] mic_div;
    logic          mic_toggle;
    logic          mic_rise;
    logic          mic_fall;

    assign mic_toggle = (mic_div == HALF_LAST);
    assign mic_rise   = mic_toggle & ~o_mic_clock;
    assign mic_fall   = mic_toggle & o_mic_clock;

    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            mic_div     <= '0;
            o_mic_clock <= 1'b0;
        end else begin
            mic_div <= mic_toggle ? '0 : mic_div + CW'(1);
            if (mic_toggle) begin
                o_mic_clock <= ~o_mic_clock;
            end
        end
    end

    // mic data is sampled in the cycle the clock edge is launched
    logic m1_first;
    logic m1_first_v;
    logic m1_second;
    logic m1_second_v;
    logic m2_first;
    logic m2_first_v;
    logic m2_second;
    logic m2_second_v;

    appr_mic_latch u_mic1 (
        .i_ref_clk      (i_ref_clk),
        .i_rst          (i_rst),
        .i_enable       (mic1_route[1]),
        .i_swap         (mic_in1_latch_edge),
        .i_rise         (mic_rise),
        .i_fall         (mic_fall),
        .i_data         (mic1_route[0]),
        .o_first        (m1_first),
        .o_first_valid  (m1_first_v),
        .o_second       (m1_second),
        .o_second_valid (m1_second_v)
    );

    appr_mic_latch u_mic2 (
        .i_ref_clk      (i_ref_clk),
        .i_rst          (i_rst),
        .i_enable       (mic2_route[1]),
        .i_swap         (mic_in2_latch_edge),
        .i_rise         (mic_rise),
        .i_fall         (mic_fall),
        .i_data         (mic2_route[0]),
        .o_first        (m2_first),
        .o_first_valid  (m2_first_v),
        .o_second       (m2_second),
        .o_second_valid (m2_second_v)
    );

    always_comb begin
        o_rec             = '0;
        o_rec.ch1_digital = rec_ch1_digital_select;
        o_rec.ch2_digital = rec_ch2_digital_select;
        // analog channels see no mic samples
        o_rec.ch1_valid   = rec_ch1_digital_select & m1_first_v;
        o_rec.ch1         = rec_ch1_digital_select & m1_first;
        o_rec.ch2_valid   = rec_ch2_digital_select & m1_second_v;
        o_rec.ch2         = rec_ch2_digital_select & m1_second;
        o_rec.ch3_valid   = m2_first_v;
        o_rec.ch3         = m2_first;
        o_rec.ch4_valid   = m2_second_v;
        o_rec.ch4         = m2_second;
    end

    // serial data output pin: level by function, then drive style
    logic            pin_level;
    logic            pin_used;
    appr_pin_drive_t next_sdout;

    always_comb begin
        pin_level = 1'b0;
        pin_used  = 1'b1;
        case (out_pin_function)
            FN_GPO:         pin_level = output_pin_setup[OUT_VALUE_BIT];
            FN_MIC_CLOCK:   pin_level = o_mic_clock;
            FN_PRIMARY_OUT: pin_level = i_primary.data_out;
            // other functions live elsewhere; pin left released here
            default:        pin_used  = 1'b0;
        endcase
    end

    always_comb begin
        next_sdout = '0;
        if (pin_used) begin
            case (out_pin_drive_style)
                DRV_PUSH_PULL: begin
                    next_sdout.oe  = 1'b1;
                    next_sdout.out = pin_level;
                end
                DRV_LOW_WEAK_HI: begin
                    next_sdout.oe      = ~pin_level;
                    next_sdout.pull_en = pin_level;
                    next_sdout.pull_up = pin_level;
                end
                DRV_OPEN_DRAIN: begin
                    next_sdout.oe = ~pin_level;
                end
                DRV_WEAK_LO_HI: begin
                    next_sdout.oe      = pin_level;
                    next_sdout.out     = pin_level;
                    next_sdout.pull_en = ~pin_level;
                end
                DRV_OPEN_SOURCE: begin
                    next_sdout.oe  = pin_level;
                    next_sdout.out = pin_level;
                end
                // hi-z, and reserved codes fall safe to hi-z
                default: next_sdout = '0;
            endcase
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            o_sdout <= '0;
        end else begin
            o_sdout <= next_sdout;
        end
    end
endmodule

// *** src/appr_pkg.sv ***
package appr_pkg;

    // register offsets
    localparam logic [7:0] ADDR_OUTPUT_PIN_SETUP     = 8'h10;
    localparam logic [7:0] ADDR_SECONDARY_CLOCK_ROUTE = 8'h11;
    localparam logic [7:0] ADDR_SECONDARY_DATA_ROUTE = 8'h12;
    localparam logic [7:0] ADDR_PDM_INPUT_SETUP      = 8'h13;

    // reset values
    localparam logic [7:0] RST_OUTPUT_PIN_SETUP      = 8'h52;
    localparam logic [7:0] RST_SECONDARY_CLOCK_ROUTE = 8'h80;
    localparam logic [7:0] RST_SECONDARY_DATA_ROUTE  = 8'h00;
    localparam logic [7:0] RST_PDM_INPUT_SETUP       = 8'h00;

    // writable bits; reserved positions stay zero
    localparam logic [7:0] WMASK_OUTPUT_PIN_SETUP      = 8'hff;
    localparam logic [7:0] WMASK_SECONDARY_CLOCK_ROUTE = 8'hfe;
    localparam logic [7:0] WMASK_SECONDARY_DATA_ROUTE  = 8'hfc;
    localparam logic [7:0] WMASK_PDM_INPUT_SETUP       = 8'hff;

    // output_pin_setup fields
    localparam int OUT_FUNC_LSB  = 4;
    localparam int OUT_VALUE_BIT = 3;
    localparam int OUT_DRIVE_LSB = 0;
    // secondary_clock_route fields
    localparam int PRIMARY_IN_EN_BIT = 7;
    localparam int SEC_FSYNC_LSB     = 4;
    localparam int SEC_BCLK_LSB      = 1;
    // secondary_data_route fields
    localparam int SEC_IN1_LSB = 5;
    localparam int SEC_IN2_LSB = 2;
    // pdm_input_setup fields
    localparam int REC_CH1_DIG_BIT   = 7;
    localparam int REC_CH2_DIG_BIT   = 6;
    localparam int MIC_IN1_EDGE_BIT  = 5;
    localparam int MIC_IN2_EDGE_BIT  = 4;
    localparam int MIC_IN1_SRC_LSB   = 2;
    localparam int MIC_IN2_SRC_LSB   = 0;

    // source codes for three-bit route fields
    localparam logic [2:0] SRC_OFF     = 3'h0;
    localparam logic [2:0] SRC_PIN_A   = 3'h1;
    localparam logic [2:0] SRC_PIN_B   = 3'h2;
    localparam logic [2:0] SRC_PIN_C   = 3'h3;
    localparam logic [2:0] SRC_SDOUT   = 3'h4;
    localparam logic [2:0] SRC_PRIMARY = 3'h5;

    // source codes for two-bit mic fields
    localparam logic [1:0] MIC_SRC_OFF   = 2'h0;
    localparam logic [1:0] MIC_SRC_PIN_A = 2'h1;
    localparam logic [1:0] MIC_SRC_PIN_B = 2'h2;
    localparam logic [1:0] MIC_SRC_PIN_C = 2'h3;

    // serial data output pin drive styles
    localparam logic [2:0] DRV_HIZ         = 3'h0;
    localparam logic [2:0] DRV_PUSH_PULL   = 3'h1;
    localparam logic [2:0] DRV_LOW_WEAK_HI = 3'h2;
    localparam logic [2:0] DRV_OPEN_DRAIN  = 3'h3;
    localparam logic [2:0] DRV_WEAK_LO_HI  = 3'h4;
    localparam logic [2:0] DRV_OPEN_SOURCE = 3'h5;

    // serial data output pin functions handled here
    localparam logic [3:0] FN_OFF         = 4'h0;
    localparam logic [3:0] FN_INPUT       = 4'h1;
    localparam logic [3:0] FN_GPO         = 4'h2;
    localparam logic [3:0] FN_MIC_CLOCK   = 4'h4;
    localparam logic [3:0] FN_PRIMARY_OUT = 4'h5;

    // mic clock timing
    localparam int REF_CLK_PERIOD_NS   = 10;
    localparam int MIC_CLK_HALF_NS     = 160;
    localparam int MIC_CLK_HALF_CYCLES =
        (MIC_CLK_HALF_NS + REF_CLK_PERIOD_NS - 1) / REF_CLK_PERIOD_NS;

    typedef struct packed {
        logic multi_pin_a;
        logic multi_pin_b;
        logic multi_pin_c;
    } appr_pins_t;

    typedef struct packed {
        logic frame_sync;
        logic bit_clock;
        logic data_in;
        logic data_out;
    } appr_primary_t;

    typedef struct packed {
        logic active;
        logic frame_sync;
        logic bit_clock;
        logic in1_valid;
        logic in1;
        logic in2_valid;
        logic in2;
    } appr_secondary_t;

    typedef struct packed {
        logic out;
        logic oe;
        logic pull_en;
        logic pull_up;
    } appr_pin_drive_t;

    typedef struct packed {
        logic ch1_digital;
        logic ch2_digital;
        logic ch1_valid;
        logic ch1;
        logic ch2_valid;
        logic ch2;
        logic ch3_valid;
        logic ch3;
        logic ch4_valid;
        logic ch4;
    } appr_rec_t;

endpackage

// *** src/appr_mic_latch.sv ***
`timescale 1ns/1ps
module appr_mic_latch (
    // clock and reset
    input  wire logic i_ref_clk,
    input  wire logic i_rst,
    // control
    input  wire logic i_enable,
    input  wire logic i_swap,
    // mic clock strobes and data
    input  wire logic i_rise,
    input  wire logic i_fall,
    input  wire logic i_data,
    // latched channels
    output logic      o_first,
    output logic      o_first_valid,
    output logic      o_second,
    output logic      o_second_valid
);
    logic first_edge;
    logic second_edge;

    // first channel on falling edge unless swapped
    assign first_edge  = i_swap ? i_rise : i_fall;
    assign second_edge = i_swap ? i_fall : i_rise;

    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            o_first       <= 1'b0;
            o_first_valid <= 1'b0;
        end else begin
            o_first_valid <= i_enable && first_edge;
            if (i_enable && first_edge) begin
                o_first <= i_data;
            end
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            o_second       <= 1'b0;
            o_second_valid <= 1'b0;
        end else begin
            o_second_valid <= i_enable && second_edge;
            if (i_enable && second_edge) begin
                o_second <= i_data;
            end
        end
    end
endmodule

// *** verification/appr_top_monitor.sv ***
`timescale 1ns/1ps
module appr_top_monitor #(
    parameter int MIC_HALF = 16
) (
    // clock, reset, writes
    input wire logic                      i_ref_clk,
    input wire logic                      i_rst,
    input wire logic [7:0]                i_reg_addr,
    input wire logic                      i_reg_wr,
    input wire logic [7:0]                i_reg_wdata,
    // pins and routed outputs
    input wire appr_pkg::appr_pins_t      i_pins,
    input wire appr_pkg::appr_primary_t   i_primary,
    input wire logic                      i_sdout_in,
    input wire appr_pkg::appr_pin_drive_t o_sdout,
    input wire logic                      o_primary_din,
    input wire appr_pkg::appr_secondary_t o_secondary,
    input wire logic                      o_mic_clock,
    input wire appr_pkg::appr_rec_t       o_rec
);
    import appr_pkg::*;
    logic [7:0] sh [4];
    logic       mc_q;
    logic       armed;
    int         hc;
    wire  [2:0] drv = sh[0][2:0];
    wire        val = sh[0][3];
    wire  [3:0] fn = sh[0][7:4];
    wire        en = sh[1][7];
    wire  [2:0] fs = sh[1][6:4];
    wire  [2:0] bc = sh[1][3:1];
    wire  [2:0] d1 = sh[2][7:5];
    wire  [7:0] pdm = sh[3];

    function automatic logic ok3(input logic [2:0] c);
        return c inside {SRC_PIN_A, SRC_PIN_B, SRC_PIN_C, SRC_PRIMARY};
    endfunction

    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            sh[0] <= RST_OUTPUT_PIN_SETUP;
            sh[1] <= RST_SECONDARY_CLOCK_ROUTE;
            sh[2] <= RST_SECONDARY_DATA_ROUTE;
            sh[3] <= RST_PDM_INPUT_SETUP;
        end else if (i_reg_wr && i_reg_addr[7:2] == 6'h04) begin
            sh[i_reg_addr[1:0]] <= i_reg_wdata;
        end
    end

    // first toggle after reset is not timed
    always_ff @(posedge i_ref_clk) begin
        mc_q <= o_mic_clock;
        if (i_rst) begin
            armed <= 1'b0;
            hc <= 0;
        end else if (o_mic_clock != mc_q) begin
            armed <= 1'b1;
            hc <= 1;
        end else begin
            hc <= hc + 1;
        end
    end

    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (i_rst);

    property p_hiz;
        drv == DRV_HIZ |=> o_sdout == '0;
    endproperty
    a_hiz: assert property (p_hiz) else $error("pin not released");
    property p_drive;
        fn == FN_GPO && drv == DRV_OPEN_DRAIN
            |=> o_sdout == ($past(val) ? 4'h0 : 4'h4);
    endproperty
    a_drive: assert property (p_drive) else $error("bad drive");
    property p_pdin;
        1'b1 |=> o_primary_din == ($past(en) && $past(i_primary.data_in));
    endproperty
    a_pdin: assert property (p_pdin) else $error("bad primary in");
    property p_fsync;
        fs == SRC_PIN_A && ok3(bc) |=> o_secondary.active
            && o_secondary.frame_sync == $past(i_pins.multi_pin_a);
    endproperty
    a_fsync: assert property (p_fsync) else $error("bad fsync");
    property p_bclk;
        bc == SRC_PRIMARY && ok3(fs)
            |=> o_secondary.bit_clock == $past(i_primary.bit_clock);
    endproperty
    a_bclk: assert property (p_bclk) else $error("bad bit clock");
    property p_off;
        !(ok3(fs) && ok3(bc)) |=> o_secondary == '0;
    endproperty
    a_off: assert property (p_off) else $error("port not idle");
    property p_in1;
        ok3(fs) && ok3(bc) && d1 == SRC_SDOUT
            |=> o_secondary.in1_valid && o_secondary.in1 == $past(i_sdout_in);
    endproperty
    a_in1: assert property (p_in1) else $error("bad input one");
    property p_type;
        o_rec.ch1_digital == pdm[7] && o_rec.ch2_digital == pdm[6];
    endproperty
    a_type: assert property (p_type) else $error("bad type");
    property p_edge;
        $rose(o_mic_clock) && $stable(pdm) && pdm[6] && !pdm[5]
            && pdm[3:2] != 2'h0 |-> ##[0:1] o_rec.ch2_valid;
    endproperty
    a_edge: assert property (p_edge) else $error("bad latch edge");
    property p_mclk;
        armed && o_mic_clock != mc_q |-> hc == MIC_HALF;
    endproperty
    a_mclk: assert property (p_mclk) else $error("bad mic period");
    c_act: cover property (o_secondary.active);
    c_ch1: cover property (o_rec.ch1_valid);
    c_ch4: cover property (o_rec.ch4_valid);
endmodule

bind appr_top appr_top_monitor #(.MIC_HALF(MIC_HALF)) u_mon (.*);

// *** verification/appr_far_model.sv ***
`timescale 1ns/1ps
module appr_far_model (
    // clock
    input  wire logic               i_ref_clk,
    // levels toward the codec
    output appr_pkg::appr_pins_t    o_pins,
    output appr_pkg::appr_primary_t o_primary,
    output logic                    o_sdout_drive
);
    logic [7:0] cnt = 8'h00;
    always_ff @(posedge i_ref_clk) begin
        cnt <= cnt + 8'h01;
    end
    assign o_primary = {cnt[4], cnt[0], cnt[2], cnt[3]};
    assign o_pins = {cnt[1], ~cnt[1], cnt[3] ^ cnt[0]};
    assign o_sdout_drive = cnt[5] ^ cnt[1];
endmodule

// *** verification/tb_top.sv ***
`timescale 1ns/1ps
module tb_top;
    import appr_pkg::*;
    logic            i_ref_clk = 1'b0;
    logic            i_rst = 1'b1;
    logic [7:0]      i_reg_addr = 8'h00;
    logic            i_reg_wr = 1'b0;
    logic            i_reg_rd = 1'b0;
    logic [7:0]      i_reg_wdata = 8'h00;
    logic [7:0]      o_reg_rdata;
    logic            i_sdout_in, far_sdout, o_primary_din, o_mic_clock;
    appr_pins_t      i_pins;
    appr_primary_t   i_primary;
    appr_pin_drive_t o_sdout;
    appr_secondary_t o_secondary;
    appr_rec_t       o_rec;
    int              err_count = 0;
    int              samples_checked = 0;

    initial begin
        forever #5 i_ref_clk = ~i_ref_clk;
    end
    assign i_sdout_in = o_sdout.oe ? o_sdout.out
                      : o_sdout.pull_en ? o_sdout.pull_up : far_sdout;

    appr_top #(.MIC_HALF(2)) dut (.*);
    appr_far_model far (
        .i_ref_clk(i_ref_clk), .o_pins(i_pins),
        .o_primary(i_primary), .o_sdout_drive(far_sdout)
    );

    task automatic chk(input string nm, input logic [7:0] e, g);
        samples_checked++;
        if (g !== e) begin
            $display("unexpected %s: expected %h seen %h", nm, e, g);
            err_count++;
        end
    endtask
    task automatic stop_test;
        $display("checks %0d mismatches %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    task automatic wr(input logic [7:0] a, d);
        @(posedge i_ref_clk);
        i_reg_addr <= a;
        i_reg_wdata <= d;
        i_reg_wr <= 1'b1;
        @(posedge i_ref_clk);
        i_reg_wr <= 1'b0;
        repeat (2) @(negedge i_ref_clk);
    endtask
    task automatic rd(input logic [7:0] a, e);
        @(posedge i_ref_clk);
        i_reg_addr <= a;
        i_reg_rd <= 1'b1;
        @(posedge i_ref_clk);
        i_reg_rd <= 1'b0;
        @(negedge i_ref_clk);
        chk("rdata", e, o_reg_rdata);
    endtask
    function automatic logic ok(input logic [2:0] c, input logic s);
        return c inside {3'h1, 3'h2, 3'h3, 3'h5} || (s && c == 3'h4);
    endfunction
    function automatic logic pick(input logic [2:0] c, input logic p);
        logic [7:0] s;
        s = {2'b00, p, i_sdout_in, i_pins.multi_pin_c, i_pins.multi_pin_b,
             i_pins.multi_pin_a, 1'b0};
        return s[c];
    endfunction

    task automatic t_regs;
        rd(ADDR_OUTPUT_PIN_SETUP, RST_OUTPUT_PIN_SETUP);
        rd(ADDR_SECONDARY_CLOCK_ROUTE, 8'h80);
        rd(ADDR_SECONDARY_DATA_ROUTE, 8'h00);
        rd(ADDR_PDM_INPUT_SETUP, 8'h00);
        wr(8'h14, 8'hff);
        rd(8'h14, 8'h00);
        wr(ADDR_SECONDARY_CLOCK_ROUTE, 8'hff);
        rd(ADDR_SECONDARY_CLOCK_ROUTE, 8'hfe);
        wr(ADDR_SECONDARY_DATA_ROUTE, 8'hff);
        rd(ADDR_SECONDARY_DATA_ROUTE, 8'hfc);
    endtask
    task automatic t_drive;
        logic [3:0] e [6] = '{4'h0, 4'h4, 4'h4, 4'h4, 4'h2, 4'h0};
        logic [3:0] h [6] = '{4'h0, 4'hc, 4'h3, 4'h0, 4'hc, 4'hc};
        logic [7:0] n;
        logic       p;
        for (int d = 0; d < 6; d++) begin
            for (int v = 0; v < 2; v++) begin
                wr(ADDR_OUTPUT_PIN_SETUP, {FN_GPO, v[0], d[2:0]});
                chk("sdout", {4'h0, v ? h[d] : e[d]},
                    {4'h0, o_sdout});
            end
        end
        wr(ADDR_OUTPUT_PIN_SETUP, {FN_MIC_CLOCK, 1'b0, DRV_PUSH_PULL});
        n = 8'h00;
        p = o_sdout.out;
        repeat (16) begin
            @(negedge i_ref_clk);
            n = n + {7'h00, o_sdout.out !== p};
            p = o_sdout.out;
        end
        chk("toggles", 8'h08, n);
    endtask
    task automatic t_pdin;
        logic e;
        for (int k = 0; k < 2; k++) begin
            wr(ADDR_SECONDARY_CLOCK_ROUTE, {k[0], 7'h00});
            repeat (6) begin
                e = k[0] & i_primary.data_in;
                @(negedge i_ref_clk);
                chk("primary", {7'h00, e}, {7'h00, o_primary_din});
            end
        end
    endtask
    task automatic t_sec(input logic [2:0] f, b, x, y);
        appr_secondary_t e;
        wr(ADDR_SECONDARY_CLOCK_ROUTE, {1'b1, f, b, 1'b0});
        wr(ADDR_SECONDARY_DATA_ROUTE, {x, y, 2'b00});
        repeat (4) begin
            e = '0;
            if (ok(f, 1'b0) && ok(b, 1'b0)) begin
                e = {1'b1, pick(f, i_primary.frame_sync),
                     pick(b, i_primary.bit_clock), ok(x, 1'b1),
                     pick(x, i_primary.data_in), ok(y, 1'b1),
                     pick(y, i_primary.data_in)};
            end
            @(negedge i_ref_clk);
            chk("secondary", {1'b0, e},
                {1'b0, o_secondary});
        end
    endtask
    task automatic t_mic(input logic [7:0] c);
        logic [7:0] n [4] = '{default: 8'h00};
        logic [7:0] bad = 8'h00;
        logic [3:0] lv, vl, on;
        lv = {c[5], !c[5], c[4], !c[4]};
        on = {c[7] && c[3:2] != 2'h0, c[6] && c[3:2] != 2'h0,
              c[1:0] != 2'h0, c[1:0] != 2'h0};
        wr(ADDR_PDM_INPUT_SETUP, c);
        chk("type", {6'h00, c[7:6]},
            {6'h00, o_rec.ch1_digital, o_rec.ch2_digital});
        repeat (32) begin
            @(negedge i_ref_clk);
            vl = {o_rec.ch1_valid, o_rec.ch2_valid,
                  o_rec.ch3_valid, o_rec.ch4_valid};
            for (int k = 0; k < 4; k++) begin
                if (vl[k] === 1'b1) begin
                    n[k] = n[k] + 8'h01;
                    bad = bad + {7'h00, o_mic_clock !== lv[k]};
                end
            end
        end
        chk("latch edge", 8'h00, bad);
        for (int k = 0; k < 4; k++) begin
            chk("valid count", on[k] ? 8'h08 : 8'h00, n[k]);
        end
    endtask

    initial begin
        repeat (8) @(posedge i_ref_clk);
        i_rst <= 1'b0;
        t_regs();
        t_drive();
        t_pdin();
        for (int c = 0; c < 8; c++) begin
            t_sec(c[2:0], SRC_PIN_A, c[2:0], ~c[2:0]);
            t_sec(SRC_PRIMARY, c[2:0], ~c[2:0], c[2:0]);
        end
        t_mic(8'hc5);
        t_mic(8'hfe);
        t_mic(8'h3a);
        t_mic(8'hc0);
        t_mic(8'h4f);
        stop_test();
    end
    initial begin
        repeat (5000) @(posedge i_ref_clk);
        err_count++;
        stop_test();
    end
endmodule
